// [pkg/tec_consts.svh]
// Constants for the timing error counter
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH
`define TEC_REF_FREQ_KHZ      1000
`define TEC_GATE_PERIOD_MS    20
`define TEC_GATE_DIVIDE       (`TEC_REF_FREQ_KHZ * `TEC_GATE_PERIOD_MS)
`define TEC_BCD_MAX           4'h9
`define TEC_BCD_ZERO          4'h0
`define TEC_ROUND_DIGIT       4'h4
`define TEC_QUIN_LAST         3'h4
`define TEC_SEG_BLANK         7'h00
`endif

// [pkg/tec_pkg.sv]
// Types for the timing error counter
package tec_pkg;
    typedef logic [3:0] tec_bcd_t;
    typedef logic [6:0] tec_seg_t;
    typedef logic [2:0] tec_quin_t;
endpackage

// [hw/tec_seg_decoder.sv]
// BCD to seven-segment decoder driver
`timescale 1ns/100ps
`include "tec_consts.svh"
module tec_seg_decoder (
    input  wire tec_pkg::tec_bcd_t digit,
    output tec_pkg::tec_seg_t      seg
);
    // Segments g..a, active high; codes above nine go dark
    always_comb begin
        case (digit)
            4'h0:    seg = 7'h3F;
            4'h1:    seg = 7'h06;
            4'h2:    seg = 7'h5B;
            4'h3:    seg = 7'h4F;
            4'h4:    seg = 7'h66;
            4'h5:    seg = 7'h6D;
            4'h6:    seg = 7'h7D;
            4'h7:    seg = 7'h07;
            4'h8:    seg = 7'h7F;
            4'h9:    seg = 7'h6F;
            default: seg = `TEC_SEG_BLANK;
        endcase
    end
endmodule // tec_seg_decoder

// [hw/tec_timing_error_counter.sv]
// Frequency error counter with gated BCD digits and LED readout
`timescale 1ns/100ps
`include "tec_consts.svh"
module tec_timing_error_counter (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              ref_clk_pin,
    input  wire logic              var_clk_pin,
    input  wire logic              led_check_pushed,
    input  wire logic              var_out_released,
    input  wire logic              subnanosecond_marker_position,
    output tec_pkg::tec_seg_t      seg_tenths,
    output tec_pkg::tec_seg_t      seg_units,
    output logic                   gate_clear,
    output logic                   display_lit
);
    function automatic tec_pkg::tec_bcd_t bcd_inc(input tec_pkg::tec_bcd_t d);
        bcd_inc = (d == `TEC_BCD_MAX) ? `TEC_BCD_ZERO : d + 4'h1;
    endfunction

    logic [2:0]          ref_sync_reg;
    logic [1:0]          var_sync_reg;
    logic [2:0]          ctl_s1_reg;
    logic [2:0]          ctl_s2_reg;
    tec_pkg::tec_bcd_t   dec0_reg, dec1_reg, dec2_reg;
    logic                half_reg;
    tec_pkg::tec_quin_t  quin_reg;
    logic                div2_reg;
    logic                mix_reg, mix_prev_reg;
    tec_pkg::tec_bcd_t   hund_reg, tenth_reg, unit_reg;
    tec_pkg::tec_seg_t   dec_tenths, dec_units;
    logic                ref_tick, chain_carry, half_carry;
    logic                clear_pulse, count_win, display_win;
    logic                meas_en, disp_en, count_pulse, lit_next;

    // Pins pass two flops; third stage only for edge finding
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_sync_reg <= 3'h0;
            var_sync_reg <= 2'h0;
            ctl_s1_reg   <= 3'h0;
            ctl_s2_reg   <= 3'h0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_pin};
            var_sync_reg <= {var_sync_reg[0], var_clk_pin};
            ctl_s1_reg   <= {subnanosecond_marker_position, var_out_released, led_check_pushed};
            ctl_s2_reg   <= ctl_s1_reg;
        end
    end

    assign ref_tick    = ref_sync_reg[1] & ~ref_sync_reg[2];
    assign chain_carry = (dec0_reg == `TEC_BCD_MAX) && (dec1_reg == `TEC_BCD_MAX)
                         && (dec2_reg == `TEC_BCD_MAX);
    assign half_carry  = chain_carry & half_reg;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dec0_reg <= `TEC_BCD_ZERO;
            dec1_reg <= `TEC_BCD_ZERO;
            dec2_reg <= `TEC_BCD_ZERO;
            half_reg <= 1'b0;
        end else if (ref_tick) begin
            dec0_reg <= bcd_inc(dec0_reg);
            if (dec0_reg == `TEC_BCD_MAX)
                dec1_reg <= bcd_inc(dec1_reg);
            if ((dec0_reg == `TEC_BCD_MAX) && (dec1_reg == `TEC_BCD_MAX))
                dec2_reg <= bcd_inc(dec2_reg);
            if (chain_carry)
                half_reg <= ~half_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            quin_reg <= 3'h0;
            div2_reg <= 1'b0;
        end else if (ref_tick && half_carry) begin
            quin_reg <= (quin_reg == `TEC_QUIN_LAST) ? 3'h0 : quin_reg + 3'h1;
            if (quin_reg == `TEC_QUIN_LAST)
                div2_reg <= ~div2_reg;
        end
    end

    assign clear_pulse = (quin_reg == `TEC_QUIN_LAST) & div2_reg;
    assign count_win   = ~div2_reg;
    assign display_win = ~(clear_pulse | count_win);
    assign meas_en     = ~ctl_s2_reg[2];
    assign disp_en     = ctl_s2_reg[0] | (ctl_s2_reg[1] & meas_en);
    assign lit_next    = display_win & disp_en;

    // Sampling mixer beats at the difference
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mix_reg      <= 1'b0;
            mix_prev_reg <= 1'b0;
        end else begin
            if (ref_tick)
                mix_reg <= var_sync_reg[1];
            mix_prev_reg <= mix_reg;
        end
    end

    assign count_pulse = mix_reg & ~mix_prev_reg & count_win & meas_en;

    always_ff @(posedge mclk) begin
        if (sys_rst || clear_pulse) begin
            hund_reg  <= `TEC_BCD_ZERO;
            tenth_reg <= `TEC_BCD_ZERO;
            unit_reg  <= `TEC_BCD_ZERO;
        end else if (count_pulse) begin
            hund_reg <= bcd_inc(hund_reg);
            if (hund_reg == `TEC_ROUND_DIGIT) begin
                tenth_reg <= bcd_inc(tenth_reg);
                if (tenth_reg == `TEC_BCD_MAX)
                    unit_reg <= bcd_inc(unit_reg);
            end
        end
    end

    tec_seg_decoder u_dec_tenths (
        .digit (tenth_reg),
        .seg   (dec_tenths)
    );
    tec_seg_decoder u_dec_units (
        .digit (unit_reg),
        .seg   (dec_units)
    );

    // Registered so the segments never glitch between digits
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seg_tenths  <= `TEC_SEG_BLANK;
            seg_units   <= `TEC_SEG_BLANK;
            gate_clear  <= 1'b0;
            display_lit <= 1'b0;
        end else begin
            seg_tenths  <= lit_next ? dec_tenths : `TEC_SEG_BLANK;
            seg_units   <= lit_next ? dec_units : `TEC_SEG_BLANK;
            gate_clear  <= clear_pulse;
            display_lit <= lit_next;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_round_step;
        count_pulse && hund_reg == 4'h4 && tenth_reg != 4'h9;
    endsequence

    AST_DIV_WRAP: assert property (
        ref_tick && chain_carry |=> half_reg != $past(half_reg) && dec0_reg == 4'h0)
        else $error("divider chain did not carry into the flip-flop");
    AST_GATE_STEP: assert property (
        ref_tick && half_carry && quin_reg == 3'h4 |=> quin_reg == 3'h0 && $changed(div2_reg))
        else $error("final stage did not wrap at five");
    AST_CLEAR_ZERO: assert property (
        clear_pulse |=> hund_reg == 4'h0 && tenth_reg == 4'h0 && unit_reg == 4'h0)
        else $error("clear pulse did not zero the digits");
    AST_COUNT_GATED: assert property (
        $changed(hund_reg) |-> $past(clear_pulse) || $past(count_win && meas_en))
        else $error("digit moved outside the counting window");
    AST_ROUNDING: assert property (
        s_round_step |=> hund_reg == 4'h5 && tenth_reg == $past(tenth_reg) + 4'h1)
        else $error("tenths did not advance at five");
    AST_HOLD: assert property (
        !count_pulse && !clear_pulse |=> $stable(hund_reg) && $stable(unit_reg))
        else $error("digit changed without cause");
    AST_WINDOW: assert property (
        display_lit |-> $past(div2_reg) && $past(quin_reg) != 3'h4)
        else $error("display lit outside its window");
    AST_BLANK: assert property (
        !disp_en |=> seg_tenths == 7'h00 && seg_units == 7'h00 && !display_lit)
        else $error("digits lit without display enable");
    AST_SUBNS: assert property (
        ctl_s2_reg[2] && !ctl_s2_reg[0] |=> !display_lit && !$changed(hund_reg)
        || $past(clear_pulse))
        else $error("measurement active in subnanosecond position");
endmodule // tec_timing_error_counter

// [bench/tec_panel_model.sv]
// Panel side model: crystal and variable clock pins with a set beat
`timescale 1ns/100ps
module tec_panel_model (
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    output logic        ref_clk_pin,
    output logic        var_clk_pin,
    output logic [15:0] ref_ticks
);
    logic [2:0] phase_reg;
    logic       beat_on;
    // Reference held low in reset, period 8 mclk
    always @(negedge mclk) begin
        if (sys_rst) begin
            phase_reg <= 3'h0;
            ref_ticks <= 16'h0000;
        end else begin
            phase_reg <= phase_reg + 3'h1;
            if (phase_reg == 3'h7) begin
                ref_ticks <= ref_ticks + 16'h0001;
            end
        end
    end
    assign ref_clk_pin = phase_reg[2];
    // Beat steps on reference fall only, never near a sampling edge
    assign beat_on = (ref_ticks < 16'h26AC) || (ref_ticks >= 16'h2904 && ref_ticks < 16'h2AF8);
    assign var_clk_pin = beat_on & ((ref_ticks / 16'h0032) % 16'h0002 == 16'h0001);
endmodule // tec_panel_model

// [bench/timing_error_counter_test.sv]
// Self-checking bench for the timing error counter
`timescale 1ns/100ps
module timing_error_counter_test;
    logic              mclk;
    logic              sys_rst;
    logic              ref_clk_pin;
    logic              var_clk_pin;
    logic              led_check_pushed;
    logic              var_out_released;
    logic              subnanosecond_marker_position;
    tec_pkg::tec_seg_t seg_tenths;
    tec_pkg::tec_seg_t seg_units;
    logic              gate_clear;
    logic              display_lit;
    logic [15:0]       ref_ticks;
    int                error_cnt = 0;
    int                comparisons = 0;

    tec_timing_error_counter u_tec_timing_error_counter (.mclk(mclk), .sys_rst(sys_rst),
        .ref_clk_pin(ref_clk_pin), .var_clk_pin(var_clk_pin),
        .led_check_pushed(led_check_pushed), .var_out_released(var_out_released),
        .subnanosecond_marker_position(subnanosecond_marker_position),
        .seg_tenths(seg_tenths), .seg_units(seg_units), .gate_clear(gate_clear),
        .display_lit(display_lit));
    tec_panel_model u_tec_panel_model (.mclk(mclk), .sys_rst(sys_rst),
        .ref_clk_pin(ref_clk_pin), .var_clk_pin(var_clk_pin), .ref_ticks(ref_ticks));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check_bit(input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic check_seg(input tec_pkg::tec_seg_t exp, input tec_pkg::tec_seg_t got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // 99 beats: hidden 9, tenths 0 after wrap, units 1
    task automatic test_count_window();
        int n;
        n = 0;
        check_bit(1'b0, display_lit);
        while (display_lit !== 1'b1 && n < 90000) begin
            @(negedge mclk);
            n++;
        end
        check_bit(1'b1, display_lit);
        check_bit(1'b1, ref_ticks >= 16'h270E && ref_ticks <= 16'h2713);
        check_seg(7'h3F, seg_tenths);
        check_seg(7'h06, seg_units);
        check_bit(1'b0, gate_clear);
        $display("test_count_window done");
    endtask

    // Panel modes as {check, released, subns, lit}
    task automatic test_enable_modes();
        logic [3:0] modes [5] = '{4'b0110, 4'b0000, 4'b1011, 4'b1111, 4'b0101};
        for (int i = 0; i < 5; i++) begin
            @(negedge mclk);
            led_check_pushed = modes[i][3];
            var_out_released = modes[i][2];
            subnanosecond_marker_position = modes[i][1];
            repeat (8) @(negedge mclk);
            check_bit(modes[i][0], display_lit);
            check_seg(modes[i][0] ? 7'h06 : 7'h00, seg_units);
        end
        $display("test_enable_modes done");
    endtask

    // Beats during display window must not move digits
    task automatic test_display_hold();
        int n;
        n = 0;
        while (ref_ticks < 16'h2B5C && n < 12000) begin
            @(negedge mclk);
            n++;
        end
        check_bit(1'b1, display_lit);
        check_seg(7'h3F, seg_tenths);
        check_seg(7'h06, seg_units);
        $display("test_display_hold done");
    endtask

    initial begin
        sys_rst = 1'b1;
        led_check_pushed = 1'b0;
        var_out_released = 1'b1;
        subnanosecond_marker_position = 1'b0;
        // Counted on rising edges; the panel model samples reset on the falling one
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        sys_rst <= 1'b0;
        test_count_window();
        test_enable_modes();
        test_display_hold();
        print_verdict();
    end

    // Run needs about 90k cycles; allow some margin
    initial begin
        #400000;
        error_cnt++;
        $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
        print_verdict();
    end
endmodule // timing_error_counter_test
